// ### tb_top.sv
// tb_top.sv: self-checking bench for the mac client controller
`include "tgm_cfg.svh"
module tb_top import tgm_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	// ===================================
	// design and model signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, tx_stream_resetn, rx_stream_resetn, tx_valid, tx_ready, rx_valid, pause_valid;
	logic rx_go = 1'b0;
	logic rx_good = 1'b0;
	tgm_tx_beat_type tx_beat;
	tgm_rx_beat_type rx_beat;
	logic [7:0] tx_gap_adjust, priority_pause_out_ack, priority_pause_send_request, g8;
	logic [7:0] priority_pause_out_valid = 8'h00;
	logic [15:0] pause_value, pval;
	logic module_presence_line = 1'b0;
	logic loss_of_light = 1'b0;
	logic module_tx_fault = 1'b0;
	logic signal_present, fault_seen;
	logic [63:0] d;
	logic [73:0] txq[$]; // expected transmit beats
	int bad_count, tests_run, pcnt, good_n, bad_n, i, g;
	int rcnt[8];

	// ===================================
	// instances
	tgm_ctrl u_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.tx_stream_resetn, .rx_stream_resetn, .tx_beat, .tx_valid, .tx_ready, .tx_gap_adjust, .rx_beat,
		.rx_valid, .pause_valid, .pause_value, .priority_pause_out_valid, .priority_pause_out_ack,
		.priority_pause_send_request, .module_presence_line, .loss_of_light, .module_tx_fault,
		.signal_present, .fault_seen);
	tgm_mac_model u_mac(.pclk, .tx_stream_resetn, .rx_stream_resetn, .tx_beat, .tx_valid, .tx_ready,
		.rx_go, .rx_good, .rx_beat, .rx_valid);

	// 200 mhz clock
	always #2.5 pclk = ~pclk;

	// ===================================
	// shared tasks
	task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
		tests_run++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one apb transfer: setup, access held until pready, then release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		if (pready !== 1'b1) begin
			bad_count++;
			stop_test();
		end else begin
			rdv = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		apb(1'b1, a, wd, unused);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] rdv);
		apb(1'b0, a, 32'h0, rdv);
	endtask

	// ===================================
	// monitors: beats against the queue, pause pulses, request lengths
	always @(posedge pclk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (txq.size() == 0) chk("tx_extra", 1, 0);
			else chk("tx_beat", 80'(tx_beat), 80'(txq.pop_front()));
		end
		if (pause_valid === 1'b1) begin
			pcnt++;
			pval = pause_value;
		end
		for (int k = 0; k < 8; k++) rcnt[k] += (priority_pause_send_request[k] === 1'b1);
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		stop_test();
	end

	// ===================================
	// main sequence
	initial begin
		void'($urandom(32'h4b46));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("rst_out", {tx_stream_resetn, rx_stream_resetn, priority_pause_out_ack}, 10'h0ff);
		rd(`TGM_OFF_CTRL, q);
		chk("ctrl", q, 32'h3);
		wr(`TGM_OFF_CTRL, 32'h0);
		chk("rst_rel", {tx_stream_resetn, rx_stream_resetn}, 2'b11);
		g8 = 8'($urandom);
		wr(`TGM_OFF_IFG, {24'h0, g8});
		chk("gap", tx_gap_adjust, g8);
		note("reset_gap");
		// six beats, each staged by three register writes, three wide then three narrow
		for (i = 0; i < 6; i++) begin
			if (i == 3) wr(`TGM_OFF_CTRL, 32'h8);
			d = {$urandom, $urandom};
			g8 = 8'($urandom);
			txq.push_back({i > 2 ? {32'h0, d[31:0]} : d, i > 2 ? g8 & 8'h0f : g8, i[0], i[1]});
			wr(`TGM_OFF_TXWORD_LO, d[31:0]);
			wr(`TGM_OFF_TXWORD_HI, d[63:32]);
			wr(`TGM_OFF_TXCMD, {22'h0, i[1], i[0], g8});
		end
		for (g = 0; g < 200 && txq.size() > 0; g++) @(posedge pclk);
		chk("tx_drain", txq.size(), 0);
		wr(`TGM_OFF_CTRL, 32'h0);
		note("tx_stream");
		g = $urandom_range(0, 16'hffff);
		wr(`TGM_OFF_PAUSE, g);
		wr(`TGM_OFF_STATUS, 32'h1);
		repeat (4) @(posedge pclk);
		chk("pause_n", pcnt, 1);
		chk("pause_v", pval, g[15:0]);
		note("pause");
		for (g = 0; g < 8; g++) begin
			wr(`TGM_OFF_PFC, 32'hff00 | (32'h1 << g));
			repeat (6) @(posedge pclk);
			chk("pfc_len", rcnt[g], 4);
		end
		priority_pause_out_valid <= 8'($urandom);
		repeat (4) @(posedge pclk);
		chk("ack_hi", priority_pause_out_ack, 8'hff);
		wr(`TGM_OFF_PFC, 32'h0);
		chk("ack_fol", priority_pause_out_ack, priority_pause_out_valid);
		rd(`TGM_OFF_STATUS, q);
		chk("pfc_seen", q[23:16] & priority_pause_out_valid, priority_pause_out_valid);
		// requests gone, so a software clear must now empty the sticky bits
		priority_pause_out_valid <= 8'h00;
		repeat (4) @(posedge pclk);
		wr(`TGM_OFF_STATUS, 32'h00ff_0000);
		rd(`TGM_OFF_STATUS, q);
		chk("pfc_clr", q[23:16], 8'h00);
		note("pfc");
		for (i = 0; i < 10; i++) begin
			rx_good <= 1'($urandom);
			rx_go <= 1'b1;
			@(posedge pclk);
			if (rx_good) good_n++;
			else bad_n++;
			rx_go <= 1'b0;
			@(posedge pclk);
		end
		repeat (4) @(posedge pclk);
		rd(`TGM_OFF_RXCNT, q);
		chk("rx_cnt", q, {bad_n[15:0], good_n[15:0]});
		rd(`TGM_OFF_RXLAST, q);
		chk("rx_last", q[0], rx_good);
		note("rx_stream");
		for (i = 0; i < 4; i++) begin
			module_presence_line <= i[0];
			loss_of_light <= i[1];
			repeat (5) @(posedge pclk);
			chk("sig", signal_present, !(i[0] | i[1]));
		end
		// backplane: present forced high and the fault pin ignored
		wr(`TGM_OFF_CTRL, 32'h4);
		module_tx_fault <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("sig_bp", {signal_present, fault_seen}, 2'b10);
		wr(`TGM_OFF_CTRL, 32'h0);
		repeat (5) @(posedge pclk);
		chk("fault", {fault_seen, tx_stream_resetn}, 2'b10);
		module_tx_fault <= 1'b0;
		repeat (4) @(posedge pclk);
		wr(`TGM_OFF_STATUS, 32'h2);
		chk("fault_clr", {fault_seen, tx_stream_resetn}, 2'b01);
		rd(12'h0fc, q);
		chk("unmapped", {err, q}, {1'b1, 32'h0});
		note("module_apb");
		stop_test();
	end
endmodule

// ### tgm_cfg.svh
// tgm_cfg.svh: offsets, field positions, reset values and timing counts for the mac client controller
`ifndef TGM_CFG_SVH
`define TGM_CFG_SVH

// =====================================================
// register offsets (byte addresses on apb)
`define TGM_OFF_CTRL 12'h000
`define TGM_OFF_IFG 12'h004
`define TGM_OFF_PAUSE 12'h008
`define TGM_OFF_PFC 12'h00c
`define TGM_OFF_STATUS 12'h010
`define TGM_OFF_TXWORD_LO 12'h014
`define TGM_OFF_TXWORD_HI 12'h018
`define TGM_OFF_TXCMD 12'h01c
`define TGM_OFF_RXCNT 12'h020
`define TGM_OFF_RXLAST 12'h024

// =====================================================
// control register fields
`define TGM_CTRL_TXRST 0
`define TGM_CTRL_RXRST 1
`define TGM_CTRL_BACKPLANE 2
`define TGM_CTRL_NARROW 3
`define TGM_CTRL_RESET 32'h0000_0003

// tx command fields
`define TGM_CMD_LAST 8
`define TGM_CMD_UNDERRUN 9
`define TGM_CMD_KEEP_MSB 7

// =====================================================
// timing and widths
`define TGM_DATA_W 64
`define TGM_KEEP_W 8
`define TGM_PRIO_N 8
`define TGM_PAUSE_W 16
`define TGM_IFG_RESET 8'h00
`define TGM_PFC_HOLD_NS 20
`define TGM_CLK_NS 5
`define TGM_PFC_HOLD_CYC ((`TGM_PFC_HOLD_NS + `TGM_CLK_NS - 1) / `TGM_CLK_NS)

`endif

// ### tgm_ctrl.sv
// tgm_ctrl.sv: apb-programmed client controller driving a 10g ethernet mac's client ports
// Function
// [RQ1] narrow option: 32-bit data, 4-bit keep
// [RQ2] client drives per-byte keep with data
// [RQ3] transmit path has own active-low reset
// [RQ4] receive path has separate active-low reset
// [RQ5] one-bit tx user flags explicit underrun
// [RQ6] timestamping widens tx user to 128
// [RQ7] 8-bit gap adjustment sets inter-packet gap
// [RQ8] client marks last beat of packet
// [RQ9] mac ready acknowledges transfer start
// [RQ10] rx user: 0 bad, 1 good
// [RQ11] mac marks last beat of packet
// [RQ12] pause valid makes mac send pause
// [RQ13] pause value presented while valid high
// [RQ14] priority ports exist only when configured; this controller always builds all eight
// [RQ15] eight per-priority pause outputs from mac
// [RQ16] quanta count only after fifo acknowledge
// [RQ17] unused priority acknowledge held high
// [RQ18] priority request makes mac send pfc
// [RQ19] signal present is nor of presence, loss
// [RQ20] client watches tx fault, resets design
// [RQ21] backplane: present 1, fault 0, off open
// [RQ22] beat moves on valid and ready
`include "tgm_cfg.svh"
module tgm_ctrl import tgm_pkg::*; (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// stream resets toward the mac
	output logic tx_stream_resetn,
	output logic rx_stream_resetn,
	// transmit stream toward the mac
	output tgm_tx_beat_type tx_beat,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_gap_adjust,
	// receive stream from the mac
	input wire tgm_rx_beat_type rx_beat,
	input wire logic rx_valid,
	// 802.3 pause request
	output logic pause_valid,
	output logic [15:0] pause_value,
	// priority flow control
	input wire logic [7:0] priority_pause_out_valid,
	output logic [7:0] priority_pause_out_ack,
	output logic [7:0] priority_pause_send_request,
	// optical module side
	input wire logic module_presence_line,
	input wire logic loss_of_light,
	input wire logic module_tx_fault,
	output logic signal_present,
	output logic fault_seen
);

	// =====================================================
	// registers
	logic [31:0] ctrl; // reset bits, backplane, narrow
	logic [7:0] ifg; // gap adjustment
	logic [15:0] pause_val; // pause quanta
	logic [7:0] pfc_req; // priority requests from software
	logic [7:0] pfc_ack_en; // priorities acknowledged at once instead of by the fifo
	logic [63:0] tx_word; // staged transmit word
	logic [15:0] rx_good_cnt; // good packets seen
	logic [15:0] rx_bad_cnt; // bad packets seen
	logic rx_last_good; // status of last packet
	logic pause_busy; // pause request held
	logic fault_flag; // sticky transmit fault
	logic [7:0] pfc_seen; // sticky priority pause seen
	tgm_tx_state_type tx_state;

	// synchronised pin levels
	logic [2:0] pins_sync;
	logic [7:0] pfc_in_sync;

	// =====================================================
	// pin synchronisers
	tgm_sync #(.WIDTH(3)) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({module_tx_fault, loss_of_light, module_presence_line}),
		.sync_out(pins_sync)
	);
	tgm_sync #(.WIDTH(8)) u_pfc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(priority_pause_out_valid),
		.sync_out(pfc_in_sync)
	);

	// =====================================================
	// apb decode
	wire logic setup_w = psel && !penable;
	wire logic access_w = psel && penable;
	wire logic wr_w = access_w && pwrite;
	wire logic hit_ctrl = paddr == `TGM_OFF_CTRL;
	wire logic hit_ifg = paddr == `TGM_OFF_IFG;
	wire logic hit_pause = paddr == `TGM_OFF_PAUSE;
	wire logic hit_pfc = paddr == `TGM_OFF_PFC;
	wire logic hit_stat = paddr == `TGM_OFF_STATUS;
	wire logic hit_lo = paddr == `TGM_OFF_TXWORD_LO;
	wire logic hit_hi = paddr == `TGM_OFF_TXWORD_HI;
	wire logic hit_cmd = paddr == `TGM_OFF_TXCMD;
	wire logic hit_cnt = paddr == `TGM_OFF_RXCNT;
	wire logic hit_last = paddr == `TGM_OFF_RXLAST;
	wire logic hit_any = hit_ctrl | hit_ifg | hit_pause | hit_pfc | hit_stat | hit_lo | hit_hi | hit_cmd
		| hit_cnt | hit_last;
	// a command write is stalled while a beat is still waiting for ready
	wire logic cmd_stall = hit_cmd && pwrite && (tx_state == TGM_TX_SEND);
	wire logic cmd_go = wr_w && hit_cmd && !cmd_stall;
	wire logic pause_done = pause_busy; // one-cycle pulse, cleared the next cycle with no acknowledge from the mac

	assign pready = access_w ? !cmd_stall : 1'b0;
	assign pslverr = access_w && !hit_any;

	// status word seen by software
	wire logic [31:0] status_w = {8'h00, pfc_seen, 8'h00, 3'h0, rx_last_good, pause_busy,
		(tx_state == TGM_TX_SEND), fault_flag, signal_present};

	// read mux
	wire logic [31:0] rd_w = hit_ctrl ? ctrl
		: hit_ifg ? {24'h0, ifg}
		: hit_pause ? {16'h0, pause_val}
		: hit_pfc ? {16'h0, pfc_ack_en, pfc_req}
		: hit_stat ? status_w
		: hit_lo ? tx_word[31:0]
		: hit_hi ? tx_word[63:32]
		: hit_cnt ? {rx_bad_cnt, rx_good_cnt}
		: hit_last ? {31'h0, rx_last_good}
		: 32'h0;

	// read data register, loaded in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup_w) begin
			prdata <= rd_w;
		end
	end

	// =====================================================
	// control and configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `TGM_CTRL_RESET;
			ifg <= `TGM_IFG_RESET;
			pause_val <= 16'h0;
			pfc_ack_en <= 8'hff;
			tx_word <= 64'h0;
		end else begin
			if (wr_w && hit_ctrl) ctrl <= {28'h0, pwdata[3:0]};
			if (wr_w && hit_ifg) ifg <= pwdata[7:0]; // see [RQ7]
			if (wr_w && hit_pause) pause_val <= pwdata[15:0];
			if (wr_w && hit_pfc) pfc_ack_en <= pwdata[15:8];
			if (wr_w && hit_lo) tx_word[31:0] <= pwdata;
			if (wr_w && hit_hi) tx_word[63:32] <= pwdata;
		end
	end

	// separate stream resets, released by software
	assign tx_stream_resetn = !ctrl[`TGM_CTRL_TXRST] && !fault_flag; // see [RQ3] see [RQ20]
	assign rx_stream_resetn = !ctrl[`TGM_CTRL_RXRST]; // see [RQ4]
	assign tx_gap_adjust = ifg;

	// =====================================================
	// transmit sequencer: one beat per command write
	wire logic beat_done = tx_valid && tx_ready; // see [RQ22] see [RQ9]
	wire logic narrow_w = ctrl[`TGM_CTRL_NARROW];
	// narrow datapath only uses the low four keep bits
	wire logic [7:0] keep_w = narrow_w ? {4'h0, pwdata[3:0]} : pwdata[7:0]; // see [RQ1] see [RQ2]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TGM_TX_IDLE;
			tx_beat <= '0;
		end else begin
			case (tx_state)
				TGM_TX_IDLE: begin
					if (cmd_go && tx_stream_resetn) begin
						tx_beat.data <= narrow_w ? {32'h0, tx_word[31:0]} : tx_word;
						tx_beat.keep <= keep_w;
						tx_beat.last <= pwdata[`TGM_CMD_LAST]; // see [RQ8]
						// no timestamping here, so the user sideband stays one bit wide
						tx_beat.user <= pwdata[`TGM_CMD_UNDERRUN]; // see [RQ5] see [RQ6]
						tx_state <= TGM_TX_SEND;
					end
				end
				TGM_TX_SEND: begin
					if (beat_done || !tx_stream_resetn) tx_state <= TGM_TX_IDLE;
				end
				default: tx_state <= TGM_TX_IDLE;
			endcase
		end
	end
	assign tx_valid = (tx_state == TGM_TX_SEND);

	// =====================================================
	// 802.3 pause: one-cycle request holding the value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_busy <= 1'b0;
			pause_value <= 16'h0;
		end else if (wr_w && hit_stat && pwdata[0] && !pause_busy) begin
			pause_busy <= 1'b1; // see [RQ12]
			pause_value <= pause_val; // see [RQ13]
		end else if (pause_done) begin
			pause_busy <= 1'b0;
		end
	end
	assign pause_valid = pause_busy;

	// =====================================================
	// priority flow control: requests held a few cycles each
	genvar g;
	generate // every priority port is always built in this controller; see [RQ14]
		for (g = 0; g < 8; g++) begin : g_prio
			logic [3:0] hold; // cycles left on this request
			logic seen; // sticky pause seen for this priority
			wire logic start_w = wr_w && hit_pfc && pwdata[g];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hold <= 4'h0;
				end else if (start_w) begin
					hold <= 4'(`TGM_PFC_HOLD_CYC); // see [RQ18]
				end else if (hold != 4'h0) begin
					hold <= hold - 4'h1;
				end
			end
			assign priority_pause_send_request[g] = hold != 4'h0;
			assign pfc_req[g] = priority_pause_send_request[g];
			// unused priorities acknowledge at once so quanta expire
			assign priority_pause_out_ack[g] = pfc_ack_en[g] ? 1'b1 : pfc_in_sync[g]; // see [RQ17] see [RQ16]
			// sticky seen, set wins over clear
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					seen <= 1'b0;
				end else if (pfc_in_sync[g]) begin
					seen <= 1'b1; // see [RQ15]
				end else if (wr_w && hit_stat && pwdata[16 + g]) begin
					seen <= 1'b0;
				end
			end
			assign pfc_seen[g] = seen;
		end
	endgenerate

	// =====================================================
	// receive side counters, always ready
	wire logic rx_end = rx_valid && rx_beat.last && rx_stream_resetn; // see [RQ11] see [RQ22]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_good_cnt <= 16'h0;
			rx_bad_cnt <= 16'h0;
			rx_last_good <= 1'b0;
		end else if (rx_end) begin
			rx_last_good <= rx_beat.user; // see [RQ10]
			if (rx_beat.user) rx_good_cnt <= rx_good_cnt + 16'h1;
			else rx_bad_cnt <= rx_bad_cnt + 16'h1;
		end
	end

	// =====================================================
	// optical module: present = nor(presence, loss) or forced in backplane
	assign signal_present = ctrl[`TGM_CTRL_BACKPLANE] ? 1'b1 : !(pins_sync[0] | pins_sync[1]); // see [RQ19] see [RQ21]

	// sticky fault, set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_flag <= 1'b0;
		end else if (pins_sync[2] && !ctrl[`TGM_CTRL_BACKPLANE]) begin
			fault_flag <= 1'b1; // see [RQ20]
		end else if (wr_w && hit_stat && pwdata[1]) begin
			fault_flag <= 1'b0;
		end
	end
	assign fault_seen = fault_flag;

	// =====================================================
	// checks
	chk_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
		tx_valid && !tx_ready && tx_stream_resetn |=> tx_valid && $stable(tx_beat)) // see [RQ22]
		else $error("tx beat changed before ready");
	chk_pause_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pause_valid |=> !pause_valid) // see [RQ12]
		else $error("pause request held too long");
	chk_pause_value: assert property (@(posedge pclk) disable iff (!presetn)
		pause_valid |-> pause_value == pause_val) // see [RQ13]
		else $error("pause value differs from register");
	chk_pfc_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(priority_pause_send_request[0]) |-> priority_pause_send_request[0] [*4] ##1
		!priority_pause_send_request[0]) // see [RQ18]
		else $error("priority request length wrong");
	chk_fault_reset: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(fault_flag) |-> !tx_stream_resetn ##1 !tx_valid) // see [RQ20] see [RQ3]
		else $error("fault did not hold tx in reset");
	chk_signal_nor: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[`TGM_CTRL_BACKPLANE] && pins_sync[1] |-> !signal_present) // see [RQ19]
		else $error("signal present with loss of light");
	chk_rx_count: assert property (@(posedge pclk) disable iff (!presetn)
		rx_end && rx_beat.user |=> rx_good_cnt == $past(rx_good_cnt) + 16'h1) // see [RQ10]
		else $error("good packet not counted");
	chk_ack_unused: assert property (@(posedge pclk) disable iff (!presetn)
		pfc_ack_en[3] |-> priority_pause_out_ack[3]) // see [RQ17]
		else $error("unused acknowledge not high");
	chk_narrow_keep: assert property (@(posedge pclk) disable iff (!presetn)
		tx_state == TGM_TX_IDLE && cmd_go && tx_stream_resetn && narrow_w |=>
		tx_valid && tx_beat.keep[7:4] == 4'h0 && tx_beat.data[63:32] == 32'h0) // see [RQ1]
		else $error("narrow beat upper lanes set");
	cov_tx_last: cover property (@(posedge pclk) beat_done && tx_beat.last);
	cov_pause: cover property (@(posedge pclk) pause_valid);
	cov_rx_bad: cover property (@(posedge pclk) rx_end && !rx_beat.user);
	cov_pfc_in: cover property (@(posedge pclk) $rose(pfc_seen[7]));

endmodule

// ### tgm_mac_model.sv
// tgm_mac_model.sv: behavioural mac stream side facing the client controller
module tgm_mac_model import tgm_pkg::*; (
	// clock and stream resets
	input wire logic pclk,
	input wire logic tx_stream_resetn,
	input wire logic rx_stream_resetn,
	// transmit stream from the controller
	input wire tgm_tx_beat_type tx_beat,
	input wire logic tx_valid,
	output logic tx_ready,
	// receive stream, launched by the bench
	input wire logic rx_go,
	input wire logic rx_good,
	output tgm_rx_beat_type rx_beat,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 100ps;

	// ===================================
	// idle values at time zero
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_beat = '0;
	end

	// ready stalls at random and stays low while the tx path is held in reset
	always @(posedge pclk) begin
		tx_ready <= tx_stream_resetn & ($urandom_range(0, 2) == 0);
	end

	// one-beat packets; idle lines toggle so stale data never looks valid
	always @(posedge pclk) begin
		rx_valid <= rx_go & rx_stream_resetn;
		rx_beat.last <= rx_go;
		rx_beat.user <= rx_go ? rx_good : ~rx_beat.user;
		rx_beat.data <= ~rx_beat.data;
		rx_beat.keep <= ~rx_beat.keep;
	end
endmodule

// ### tgm_pkg.sv
// tgm_pkg.sv: types for the mac client controller
package tgm_pkg;

	// =====================================================
	// transmit beat toward the mac
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] keep;
		logic last;
		logic [0:0] user;
	} tgm_tx_beat_type;

	// receive beat from the mac
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] keep;
		logic last;
		logic user;
	} tgm_rx_beat_type;

	// transmit sequencer states
	typedef enum logic [1:0] {
		TGM_TX_IDLE,
		TGM_TX_SEND
	} tgm_tx_state_type;

endpackage

// ### tgm_sync.sv
// tgm_sync.sv: two-flop synchroniser for a group of asynchronous pin levels
module tgm_sync import tgm_pkg::*; #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// first stage, read only by the second
	logic [WIDTH-1:0] meta;

	// =====================================================
	// two flops in series
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule
